// ===== gpb_pkg.sv
// package: register map, payload layout and states of the payload builder
package gpb_pkg;
    localparam int MAC_MAX = 8;
    localparam int VLAN_MAX = 15;
    localparam int MAC_BYTES = 6;
    localparam int CFG_BITS = 4;
    // payload byte offsets, relative to the start of the payload
    localparam logic [7:0] PL_MAC_CNT = 8'h00;
    localparam logic [7:0] PL_MAC_FLG = 8'h03;
    localparam logic [7:0] PL_VLAN_CNT = 8'h04;
    localparam logic [7:0] PL_VLAN_FLG = 8'h06;
    localparam logic [7:0] PL_LINK = 8'h08;
    localparam logic [7:0] PL_BCAST = 8'h0C;
    localparam logic [7:0] PL_CFG = 8'h10;
    localparam logic [7:0] PL_VMODE = 8'h14;
    localparam logic [7:0] PL_FLOW = 8'h15;
    localparam logic [7:0] PL_AEN = 8'h18;
    localparam logic [7:0] PL_FIXED_LEN = 8'h1C;
    // register word addresses (byte address / 4)
    localparam logic [5:0] A_CTRL = 6'h00;
    localparam logic [5:0] A_STATUS = 6'h01;
    localparam logic [5:0] A_MAC_EN = 6'h02;
    localparam logic [5:0] A_VLAN_EN = 6'h03;
    localparam logic [5:0] A_LINK = 6'h04;
    localparam logic [5:0] A_BCAST = 6'h05;
    localparam logic [5:0] A_CFG = 6'h06;
    localparam logic [5:0] A_MODES = 6'h07;
    localparam logic [5:0] A_AEN = 6'h08;
    localparam logic [5:0] A_LEN = 6'h09;
    localparam logic [5:0] A_MAC_LO = 6'h10;
    localparam logic [5:0] A_MAC_HI = 6'h18;
    localparam logic [5:0] A_VLAN = 6'h20;
    localparam logic [31:0] UNMAPPED = 32'h0000_0000;
    typedef enum logic [1:0] {
        GPB_IDLE = 2'b00,
        GPB_SEND = 2'b01,
        GPB_DONE = 2'b11
    } gpb_state_t;
endpackage

// ===== gpb_regs.sv
// avalon-mm register file holding the channel's stored parameters
`timescale 1ns/1ps
module gpb_regs #(
    parameter int MAC_N = 8,
    parameter int VLAN_N = 15
) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [5:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire logic busy_in,
    input wire logic [7:0] length_in,
    output logic start_out,
    output logic [7:0] mac_en_out,
    output logic [14:0] vlan_en_out,
    output logic [31:0] link_out,
    output logic [31:0] bcast_out,
    output logic [3:0] cfg_out,
    output logic [15:0] modes_out,
    output logic [31:0] aen_out,
    output logic [47:0] mac_out [8],
    output logic [15:0] vlan_out [15]
);
    logic ack_reg;
    logic [31:0] rd_reg;
    logic [31:0] rd_next;
    wire logic req = (read_in | write_in) & ~ack_reg;
    // a write lands only at the edge where waitrequest is seen low
    wire logic wr = write_in & ack_reg;
    wire logic [31:0] bmask = {{8{byteenable_in[3]}}, {8{byteenable_in[2]}},
        {8{byteenable_in[1]}}, {8{byteenable_in[0]}}};
    wire logic [31:0] wval = writedata_in & bmask;
    wire logic [2:0] mac_idx = address_in[2:0];
    wire logic [3:0] vl_idx = address_in[3:0];
    wire logic is_mac_lo = address_in[5:3] == gpb_pkg::A_MAC_LO[5:3];
    wire logic is_mac_hi = address_in[5:3] == gpb_pkg::A_MAC_HI[5:3];
    wire logic is_vlan = address_in[5:4] == gpb_pkg::A_VLAN[5:4]
        && vl_idx != 4'hF;

    // one wait cycle: answer lands on the edge after the request is seen
    assign waitrequest_out = ~ack_reg;
    assign readdata_out = rd_reg;

    always_comb
    begin
        rd_next = gpb_pkg::UNMAPPED;
        case (address_in)
            gpb_pkg::A_STATUS: rd_next = {23'h000000, busy_in, length_in};
            gpb_pkg::A_MAC_EN: rd_next = {24'h000000, mac_en_out};
            gpb_pkg::A_VLAN_EN: rd_next = {17'h00000, vlan_en_out};
            gpb_pkg::A_LINK: rd_next = link_out;
            gpb_pkg::A_BCAST: rd_next = bcast_out;
            gpb_pkg::A_CFG: rd_next = {28'h0000000, cfg_out};
            gpb_pkg::A_MODES: rd_next = {16'h0000, modes_out};
            gpb_pkg::A_AEN: rd_next = aen_out;
            gpb_pkg::A_LEN: rd_next = {24'h000000, length_in};
            default:
            begin
                if (is_mac_lo)
                    rd_next = mac_out[mac_idx][31:0];
                else if (is_mac_hi)
                    rd_next = {16'h0000, mac_out[mac_idx][47:32]};
                else if (is_vlan)
                    rd_next = {16'h0000, vlan_out[vl_idx]};
                else
                    rd_next = gpb_pkg::UNMAPPED;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            ack_reg <= 1'b0;
            rd_reg <= 32'h0000_0000;
            start_out <= 1'b0;
        end
        else
        begin
            ack_reg <= req;
            rd_reg <= rd_next;
            start_out <= wr && address_in == gpb_pkg::A_CTRL
                && byteenable_in[0] && writedata_in[0];
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            mac_en_out <= 8'h00;
            vlan_en_out <= 15'h0000;
            link_out <= 32'h0000_0000;
            bcast_out <= 32'h0000_0000;
            cfg_out <= 4'h0;
            modes_out <= 16'h0000;
            aen_out <= 32'h0000_0000;
        end
        else if (wr)
        begin
            case (address_in)
                gpb_pkg::A_MAC_EN:
                    mac_en_out <= (mac_en_out & ~bmask[7:0]) | wval[7:0];
                gpb_pkg::A_VLAN_EN:
                    vlan_en_out <= (vlan_en_out & ~bmask[14:0]) | wval[14:0];
                gpb_pkg::A_LINK: link_out <= (link_out & ~bmask) | wval;
                gpb_pkg::A_BCAST: bcast_out <= (bcast_out & ~bmask) | wval;
                gpb_pkg::A_CFG: cfg_out <= (cfg_out & ~bmask[3:0]) | wval[3:0];
                gpb_pkg::A_MODES:
                    modes_out <= (modes_out & ~bmask[15:0]) | wval[15:0];
                gpb_pkg::A_AEN: aen_out <= (aen_out & ~bmask) | wval;
                default:
                begin
                end
            endcase
        end
    end

    genvar i;
    generate
        for (i = 0; i < 8; i++)
        begin : g_mac
            always_ff @(posedge ref_clk_in)
            begin
                if (srst_in)
                    mac_out[i] <= 48'h0000_0000_0000;
                else if (wr && is_mac_lo && mac_idx == i)
                    mac_out[i][31:0] <= (mac_out[i][31:0] & ~bmask) | wval;
                else if (wr && is_mac_hi && mac_idx == i)
                    mac_out[i][47:32] <= (mac_out[i][47:32] & ~bmask[15:0])
                        | wval[15:0];
            end
        end
        for (i = 0; i < 15; i++)
        begin : g_vlan
            always_ff @(posedge ref_clk_in)
            begin
                if (srst_in)
                    vlan_out[i] <= 16'h0000;
                else if (wr && is_vlan && vl_idx == i)
                    vlan_out[i] <= (vlan_out[i] & ~bmask[15:0]) | wval[15:0];
            end
        end
    endgenerate
endmodule

// ===== gpb_field_mux.sv
// combinational byte selector for the fixed and variable payload fields
`timescale 1ns/1ps
module gpb_field_mux #(
    parameter int MAC_N = 4,
    parameter int VLAN_N = 4
) (
    input wire logic [7:0] idx_in,
    input wire logic [7:0] mac_cnt_in,
    input wire logic [7:0] vlan_cnt_in,
    input wire logic [7:0] mac_flg_in,
    input wire logic [14:0] vlan_flg_in,
    input wire logic [31:0] link_in,
    input wire logic [31:0] bcast_in,
    input wire logic [31:0] cfg_in,
    input wire logic [15:0] modes_in,
    input wire logic [31:0] aen_in,
    input wire logic [47:0] mac_in [8],
    input wire logic [15:0] vlan_in [15],
    output logic [7:0] byte_out
);
    localparam logic [7:0] MAC_END = 8'(gpb_pkg::PL_FIXED_LEN
        + 8'(MAC_N * gpb_pkg::MAC_BYTES));
    wire logic [7:0] woff = idx_in & 8'hFC;
    wire logic [1:0] lane = 2'(3 - idx_in[1:0]);
    wire logic [7:0] moff = 8'(idx_in - gpb_pkg::PL_FIXED_LEN);
    wire logic [7:0] mnum = 8'(moff / 8'd6);
    wire logic [2:0] mbyte = 3'(5 - (moff % 8'd6));
    wire logic [7:0] voff = 8'(idx_in - MAC_END);
    wire logic [7:0] vnum = {1'b0, voff[7:1]};
    wire logic [31:0] word_sel =
        woff == gpb_pkg::PL_MAC_CNT ? {mac_cnt_in, 16'h0000, mac_flg_in} :
        woff == gpb_pkg::PL_VLAN_CNT ? {vlan_cnt_in, 9'h000, vlan_flg_in} :
        woff == gpb_pkg::PL_LINK ? link_in :
        woff == gpb_pkg::PL_BCAST ? bcast_in :
        woff == gpb_pkg::PL_CFG ? cfg_in :
        woff == gpb_pkg::PL_VMODE ? {modes_in, 16'h0000} :
        woff == gpb_pkg::PL_AEN ? aen_in : 32'h0000_0000;

    always_comb
    begin
        byte_out = 8'h00;
        if (idx_in < gpb_pkg::PL_FIXED_LEN)
            byte_out = word_sel[8 * lane +: 8];
        else if (idx_in < MAC_END)
            // entries back to back, most significant byte first [R14]
            byte_out = mac_in[mnum[2:0]][8 * mbyte +: 8];
        else
            // tag entries follow directly, high byte first [R8]
            byte_out = idx_in[0] ? vlan_in[vnum[3:0]][7:0]
                : vlan_in[vnum[3:0]][15:8];
    end
endmodule

// ===== gpb_builder.sv
// parameter readback response payload builder: byte stream generator
// Operation
// R1: the MAC address count field carries the number of address entries.
// R2: the VLAN tag count field carries the number of tag entries.
// R3: address flag bit n-1 is 1 when address entry n is enabled, else 0.
// R4: tag flag bits 0 to 14 are 1 when tag entries 1 to 15 are enabled.
// R5: link settings are returned as the 32-bit value set by software.
// R6: broadcast filter settings are returned as the applied 32-bit value.
// R7: up to eight six-byte address entries are returned.
// R8: up to fifteen sixteen-bit tag entries are returned.
// R9: the receiver trusts a value only when its enable bit is set.
// R10: config flag bits 0..3 are broadcast, channel, transmit, multicast.
// R11: every readback request is accepted and answered; here further requests while one is pending merge into one response.
// R12: unsupported parameters read as zero.
// R13: unicast entries come first, then multicast, then mixed entries.
// R14: supported addresses sit back to back at the end of the payload; here the tag entries follow them.
// R15: reserved flag bits and flags of unsupported entries read as zero.
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module gpb_builder #(
    parameter int MAC_UNI = 2,
    parameter int MAC_MULTI = 1,
    parameter int MAC_MIXED = 1,
    parameter int VLAN_N = 4
) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic req_in,
    input wire logic ready_in,
    output logic valid_out,
    output logic [7:0] data_out,
    output logic first_out,
    output logic last_out,
    output logic busy_out
);
    localparam int MAC_N = MAC_UNI + MAC_MULTI + MAC_MIXED;
    localparam logic [7:0] LEN = 8'(gpb_pkg::PL_FIXED_LEN
        + 8'(MAC_N * gpb_pkg::MAC_BYTES) + 8'(VLAN_N * 2));

    gpb_pkg::gpb_state_t state_reg;
    gpb_pkg::gpb_state_t state_next;
    logic [7:0] idx_reg;
    logic [7:0] idx_next;
    logic pend_reg;
    logic req_s1_reg;
    logic req_s2_reg;
    logic req_s3_reg;
    logic sw_start;
    logic [7:0] mac_en;
    logic [14:0] vlan_en;
    logic [31:0] link_val;
    logic [31:0] bcast_val;
    logic [3:0] cfg_val;
    logic [15:0] modes_val;
    logic [31:0] aen_val;
    logic [47:0] mac_val [8];
    logic [15:0] vlan_val [15];
    logic [47:0] mac_sup [8];
    logic [15:0] vlan_sup [15];
    logic [7:0] mux_byte;

    // entry 0..MAC_UNI-1 unicast, then multicast, then mixed filters [R13]
    // unsupported entries are forced to zero [R12]
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_mac_sup
            assign mac_sup[g] = g < MAC_N ? mac_val[g] : 48'h0000_0000_0000;
        end
        for (g = 0; g < 15; g++)
        begin : g_vlan_sup
            assign vlan_sup[g] = g < VLAN_N ? vlan_val[g] : 16'h0000;
        end
    endgenerate

    wire logic [7:0] mac_sup_mask = 8'((9'h001 << MAC_N) - 9'h001);
    wire logic [14:0] vlan_sup_mask = 15'((16'h0001 << VLAN_N) - 16'h0001);
    wire logic [7:0] mac_flags = mac_en & mac_sup_mask; // [R3] [R15]
    wire logic [14:0] vlan_flags = vlan_en & vlan_sup_mask; // [R4] [R15]
    wire logic [31:0] cfg_word = {28'h0000000, cfg_val}; // [R10] [R15]
    wire logic [7:0] mac_cnt = 8'(MAC_N); // [R1]
    wire logic [7:0] vlan_cnt = 8'(VLAN_N); // [R2]

    gpb_regs #(
        .MAC_N(MAC_N),
        .VLAN_N(VLAN_N)
    ) u_regs (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .address_in(avs_address),
        .read_in(avs_read),
        .write_in(avs_write),
        .writedata_in(avs_writedata),
        .byteenable_in(avs_byteenable),
        .readdata_out(avs_readdata),
        .waitrequest_out(avs_waitrequest),
        .busy_in(busy_out),
        .length_in(LEN),
        .start_out(sw_start),
        .mac_en_out(mac_en),
        .vlan_en_out(vlan_en),
        .link_out(link_val),
        .bcast_out(bcast_val),
        .cfg_out(cfg_val),
        .modes_out(modes_val),
        .aen_out(aen_val),
        .mac_out(mac_val),
        .vlan_out(vlan_val)
    );

    gpb_field_mux #(
        .MAC_N(MAC_N),
        .VLAN_N(VLAN_N)
    ) u_mux (
        .idx_in(idx_reg),
        .mac_cnt_in(mac_cnt),
        .vlan_cnt_in(vlan_cnt),
        .mac_flg_in(mac_flags),
        .vlan_flg_in(vlan_flags),
        .link_in(link_val), // [R5]
        .bcast_in(bcast_val), // [R6]
        .cfg_in(cfg_word),
        .modes_in(modes_val),
        .aen_in(aen_val),
        .mac_in(mac_sup), // [R7]
        .vlan_in(vlan_sup), // [R8]
        .byte_out(mux_byte)
    );

    // request pin is asynchronous; rising edge taken after two flops
    wire logic req_rise = req_s2_reg & ~req_s3_reg;
    wire logic take = state_reg == gpb_pkg::GPB_IDLE && pend_reg;
    wire logic beat_done = valid_out & ready_in;
    wire logic at_last = idx_reg == 8'(LEN - 8'd1);
    // idx_reg names the next byte to load; LEN means all bytes are loaded
    wire logic more = idx_reg != LEN;
    wire logic load = state_reg == gpb_pkg::GPB_SEND && more
        && (!valid_out || beat_done);
    wire logic fin = beat_done && last_out;

    always_comb
    begin
        state_next = state_reg;
        idx_next = idx_reg;
        case (state_reg)
            gpb_pkg::GPB_IDLE:
            begin
                if (pend_reg) // [R11]
                begin
                    state_next = gpb_pkg::GPB_SEND;
                    idx_next = 8'h00;
                end
            end
            gpb_pkg::GPB_SEND:
            begin
                if (fin)
                    state_next = gpb_pkg::GPB_DONE;
                if (load)
                    idx_next = 8'(idx_reg + 8'd1);
            end
            gpb_pkg::GPB_DONE:
                state_next = gpb_pkg::GPB_IDLE;
            default:
                state_next = gpb_pkg::GPB_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            req_s3_reg <= 1'b0;
            pend_reg <= 1'b0;
        end
        else
        begin
            req_s1_reg <= req_in;
            req_s2_reg <= req_s1_reg;
            req_s3_reg <= req_s2_reg;
            // a request during a send is held; further ones before it is taken merge into it [R11]
            pend_reg <= req_rise | sw_start | (pend_reg & ~take);
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            state_reg <= gpb_pkg::GPB_IDLE;
            idx_reg <= 8'h00;
        end
        else
        begin
            state_reg <= state_next;
            idx_reg <= idx_next;
        end
    end

    // output stage registered; byte held while ready is low
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
        begin
            valid_out <= 1'b0;
            data_out <= 8'h00;
            first_out <= 1'b0;
            last_out <= 1'b0;
            busy_out <= 1'b0;
        end
        else
        begin
            busy_out <= state_next != gpb_pkg::GPB_IDLE;
            if (load)
            begin
                valid_out <= 1'b1;
                data_out <= mux_byte;
                first_out <= idx_reg == 8'h00;
                last_out <= at_last; // [R14]
            end
            else if (beat_done)
            begin
                valid_out <= 1'b0;
                first_out <= 1'b0;
                last_out <= 1'b0;
            end
        end
    end
endmodule

// ===== gpb_builder_asserts.sv
// checker on the payload byte stream of the readback builder
`timescale 1ns/1ps
module gpb_builder_asserts #(
    parameter int MAC_UNI = 2,
    parameter int MAC_MULTI = 1,
    parameter int MAC_MIXED = 1,
    parameter int VLAN_N = 4
) (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic ready_in,
    input wire logic valid_out,
    input wire logic [7:0] data_out,
    input wire logic first_out,
    input wire logic last_out
);
    localparam int MN = MAC_UNI + MAC_MULTI + MAC_MIXED;
    localparam int LEN = 28 + 6 * MN + 2 * VLAN_N;
    logic [7:0] idx_reg;
    logic [7:0] idx_next;
    wire xfer = valid_out && ready_in;
    // index restarts only on a marked last byte
    assign idx_next = (xfer && last_out) ? 8'h00 : idx_reg + 8'h01;
    always_ff @(posedge ref_clk_in)
    begin
        if (srst_in)
            idx_reg <= 8'h00;
        else if (xfer)
            idx_reg <= idx_next;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    AST_MAC_COUNT: assert property (
        xfer && idx_reg == 8'h00 |-> data_out == 8'(MN))
        else $error("address count byte wrong");
    AST_VLAN_COUNT: assert property (
        xfer && idx_reg == 8'h04 |-> data_out == 8'(VLAN_N))
        else $error("tag count byte wrong");
    AST_MAC_FLAGS: assert property (
        xfer && idx_reg == 8'h03 |-> (16'(data_out) >> MN) == 16'h0)
        else $error("address flag of missing entry set");
    AST_VLAN_FLAGS: assert property (
        (xfer && idx_reg == 8'h06 |-> ((16'(data_out) << 8) >> VLAN_N) == 0)
        and (xfer && idx_reg == 8'h07 |-> (16'(data_out) >> VLAN_N) == 0))
        else $error("tag flag of missing entry set");
    AST_CFG_RESERVED: assert property (
        xfer && idx_reg[7:2] == 6'h04 |-> data_out[7:4] == 4'h0
        && (idx_reg[1:0] == 2'h3 || data_out == 8'h00))
        else $error("reserved config flag set");
    AST_RESERVED_ZERO: assert property (
        xfer && idx_reg inside {8'h01, 8'h02, 8'h05, 8'h16, 8'h17}
        |-> data_out == 8'h00)
        else $error("reserved byte not zero");
    AST_FIRST: assert property (
        xfer |-> first_out == (idx_reg == 8'h00))
        else $error("first marker misplaced");
    AST_LAST: assert property (
        xfer |-> last_out == (idx_reg == 8'(LEN - 1)))
        else $error("last marker misplaced");
    AST_HOLD: assert property (
        valid_out && !ready_in |=> valid_out && $stable(data_out)
        && $stable(last_out))
        else $error("byte dropped during stall");
    cover property (xfer && first_out);
    cover property (xfer && last_out);
    cover property (valid_out && !ready_in);
endmodule

// ===== gpb_mc_sink.sv
// management controller model that takes in payload bytes
`timescale 1ns/1ps
module gpb_mc_sink (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic stall_in,
    input wire logic valid_in,
    input wire logic [7:0] data_in,
    input wire logic first_in,
    input wire logic last_in,
    output logic ready_out
);
    logic [9:0] got [$];
    logic [1:0] cnt_reg = 2'h0;
    initial ready_out = 1'b0;
    // fields are trusted only under their enable bit, judged by the bench
    always @(posedge ref_clk_in)
    begin
        if (srst_in)
            ready_out <= 1'b0;
        else
        begin
            if (valid_in && ready_out)
                got.push_back({first_in, last_in, data_in});
            cnt_reg <= cnt_reg + 2'h1;
            ready_out <= !stall_in || cnt_reg == 2'h2;
        end
    end
endmodule

// ===== tb_gpb_builder.sv
// testbench for the readback payload builder
`timescale 1ns/1ps
module tb_gpb_builder;
    localparam int MN = 4;
    localparam int VN = 4;
    localparam int PLEN = 28 + 6 * MN + 2 * VN;
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic req_in = 1'b0;
    logic stall = 1'b0;
    logic ready_in;
    logic valid_out;
    logic [7:0] data_out;
    logic first_out;
    logic last_out;
    logic busy_out;
    int err_total = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [31:0] regv [9] = '{default: 32'h0};
    logic [47:0] mac [8] = '{default: 48'h0};
    logic [15:0] vlan [15] = '{default: 16'h0};
    logic [7:0] exp_q [$];
    always #4 ref_clk_in = ~ref_clk_in;
    gpb_builder #(.MAC_UNI(2), .MAC_MULTI(1), .MAC_MIXED(1), .VLAN_N(VN)) dut (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .req_in(req_in),
        .ready_in(ready_in), .valid_out(valid_out), .data_out(data_out),
        .first_out(first_out), .last_out(last_out), .busy_out(busy_out));
    gpb_mc_sink mc (
        .ref_clk_in(ref_clk_in), .srst_in(srst_in), .stall_in(stall),
        .valid_in(valid_out), .data_in(data_out), .first_in(first_out),
        .last_in(last_out), .ready_out(ready_in));
    task automatic complete_run();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk_in);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        @(posedge ref_clk_in);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk_in);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic push_word(input logic [31:0] w);
        for (int i = 3; i >= 0; i--)
            exp_q.push_back(w[8*i+:8]);
    endtask
    // missing entries must read back with their flags cleared
    task automatic build_exp();
        exp_q = {8'(MN), 8'h00, 8'h00, regv[2][7:0] & 8'h0F, 8'(VN), 8'h00,
                 8'h00, regv[3][7:0] & 8'h0F};
        push_word(regv[4]);
        push_word(regv[5]);
        push_word(regv[6] & 32'h0000_000F);
        push_word({regv[7][15:0], 16'h0});
        push_word(regv[8]);
        for (int n = 0; n < MN; n++)
            for (int k = 5; k >= 0; k--)
                exp_q.push_back(mac[n][8*k+:8]);
        for (int n = 0; n < VN; n++)
        begin
            exp_q.push_back(vlan[n][15:8]);
            exp_q.push_back(vlan[n][7:0]);
        end
    endtask
    task automatic run_resp(input logic by_pin);
        int n;
        mc.got.delete();
        build_exp();
        if (by_pin)
        begin
            @(posedge ref_clk_in);
            req_in <= 1'b1;
            repeat (4) @(posedge ref_clk_in);
            req_in <= 1'b0;
        end
        else
            bus(1'b1, gpb_pkg::A_CTRL, 32'h1);
        while (valid_out !== 1'b1)
            @(posedge ref_clk_in);
        check(32'(busy_out), 32'h1);
        n = 0;
        while (mc.got.size() < PLEN && n < 2000)
        begin
            @(posedge ref_clk_in);
            n++;
        end
        repeat (8) @(posedge ref_clk_in);
        check(32'(busy_out), 32'h0);
        check(32'(mc.got.size()), 32'(PLEN));
        for (int i = 0; i < PLEN && i < mc.got.size(); i++)
        begin
            check(32'(mc.got[i][7:0]), 32'(exp_q[i]));
            check(32'(mc.got[i][9:8]), 32'({i == 0, i == PLEN - 1}));
        end
        // the enable nibble the receiver must consult before trusting values
        check(32'(mc.got[19][3:0]), regv[6] & 32'h0000_000F);
    endtask
    task automatic sc_regs();
        bus(1'b0, gpb_pkg::A_LINK, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, 6'h3F, 32'hDEAD_BEEF);
        bus(1'b0, 6'h3F, 32'h0);
        check(rd, gpb_pkg::UNMAPPED);
        bus(1'b0, gpb_pkg::A_LEN, 32'h0);
        check(rd, 32'(PLEN));
        bus(1'b1, gpb_pkg::A_LINK, 32'hA5C3_0F81);
        bus(1'b0, gpb_pkg::A_LINK, 32'h0);
        check(rd, 32'hA5C3_0F81);
        bus(1'b1, gpb_pkg::A_LINK, 32'h0);
    endtask
    task automatic sc_full();
        regv = '{32'h0, 32'h0, 32'hFF, 32'h7FFF, 32'h8123_4567, 32'hF,
                 32'hFFFF_FFFF, 32'h0305, 32'h7};
        for (int a = 2; a <= 8; a++)
            bus(1'b1, 6'(a), regv[a]);
        for (int n = 0; n < 8; n++)
        begin
            mac[n] = 48'h0A1B_2C3D_4E50 + 48'(n);
            bus(1'b1, gpb_pkg::A_MAC_LO + 6'(n), mac[n][31:0]);
            bus(1'b1, gpb_pkg::A_MAC_HI + 6'(n), {16'h0, mac[n][47:32]});
        end
        for (int n = 0; n < 15; n++)
        begin
            vlan[n] = 16'h0A10 + 16'(n);
            bus(1'b1, gpb_pkg::A_VLAN + 6'(n), {16'h0, vlan[n]});
        end
        stall <= 1'b1;
        run_resp(1'b0);
        stall <= 1'b0;
    endtask
    task automatic sc_cfg_bits();
        for (int i = 0; i < 4; i++)
        begin
            regv[6] = 32'h1 << i;
            bus(1'b1, gpb_pkg::A_CFG, regv[6]);
            run_resp(i[0]);
        end
    endtask
    initial
    begin
        repeat (16) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        sc_regs();
        run_resp(1'b1);
        sc_full();
        sc_cfg_bits();
        complete_run();
    end
endmodule
bind gpb_builder gpb_builder_asserts #(.MAC_UNI(MAC_UNI),
    .MAC_MULTI(MAC_MULTI), .MAC_MIXED(MAC_MIXED), .VLAN_N(VLAN_N)) u_chk (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .ready_in(ready_in),
    .valid_out(valid_out), .data_out(data_out), .first_out(first_out),
    .last_out(last_out));
